// *** hw/exu_consts.svh ***
// constants of the instruction execute subset: widths, offsets, reset values, counts
`ifndef EXU_CONSTS_SVH
`define EXU_CONSTS_SVH

// widths
`define EXU_DATA_W 8
`define EXU_FILE_DEPTH 128
`define EXU_FILE_AW 7
`define EXU_ADDR_W 8
`define EXU_LIT_W 11
`define EXU_PC_W 15
`define EXU_LATCH_W 7

// pc field positions and latch page bits
`define EXU_PC_LOW_MSB 10
`define EXU_PC_HIGH_LSB 11
`define EXU_LATCH_PAGE_MSB 6
`define EXU_LATCH_PAGE_LSB 3

// register port offsets, data file occupies 8'h00..8'h7f
`define EXU_OFS_FILE_LAST 8'h7f
`define EXU_OFS_WORK 8'h80
`define EXU_OFS_STATUS 8'h81
`define EXU_OFS_LATCH 8'h82
`define EXU_OFS_PC_LOW 8'h83
`define EXU_OFS_PC_HIGH 8'h84

// reset values
`define EXU_RST_DATA 8'h00
`define EXU_RST_PC 15'h0000
`define EXU_RST_LATCH 7'h00

// pc steps in instruction words
`define EXU_PC_STEP 15'h0001
`define EXU_PC_SKIP_STEP 15'h0002

`endif

// *** hw/exu_pkg.sv ***
// types of the instruction execute subset
package exu_pkg;

	// decoded operation presented to the execute unit
	typedef enum logic [2:0] {
		nop_op,
		decrement_register_op,
		clear_working_op,
		decrement_skip_zero_op,
		increment_skip_zero_op,
		unconditional_branch_op,
		or_literal_op
	} exu_op_type;

	// run: accepts an instruction, nop_slot: forced no-operation cycle
	typedef enum {
		EXU_RUN,
		EXU_NOP_SLOT
	} exu_state_type;

endpackage

// *** hw/exu_execute.sv ***
// execute unit for a subset of an 8-bit core: file decrement/increment, skips, branch, or
`timescale 1ns/1ps
`include "exu_consts.svh"

module exu_execute #(
	parameter int DATA_W = `EXU_DATA_W,
	parameter int FILE_DEPTH = `EXU_FILE_DEPTH
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic NRST,
	// decoded instruction, taken when valid and ready are both high
	input wire logic INSTR_VALID,
	input wire exu_pkg::exu_op_type INSTR_OP,
	input wire logic [`EXU_FILE_AW-1:0] INSTR_FILE,
	input wire logic INSTR_DEST,
	input wire logic [`EXU_LIT_W-1:0] INSTR_LIT,
	output logic INSTR_READY,
	// core state
	output logic [`EXU_PC_W-1:0] PC_OUT,
	output logic [DATA_W-1:0] WORK_OUT,
	output logic ZERO_OUT,
	output logic NOP_CYCLE,
	// register port
	input wire logic [`EXU_ADDR_W-1:0] REG_ADDR,
	input wire logic [DATA_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [DATA_W-1:0] REG_RDATA
);
	import exu_pkg::*;

	// ==========================================================
	// elaboration checks
	// datapath is fixed to 8-bit results and a 7-bit file index
	if (DATA_W != `EXU_DATA_W) begin : g_bad_width
		$error("exu_execute: DATA_W must be 8");
	end
	if (FILE_DEPTH < 1 || FILE_DEPTH > `EXU_FILE_DEPTH) begin : g_bad_depth
		$error("exu_execute: FILE_DEPTH must be 1 to 128");
	end

	// ==========================================================
	// functions
	function automatic logic is_zero(input logic [`EXU_DATA_W-1:0] value);
		is_zero = (value == `EXU_RST_DATA);
	endfunction

	function automatic logic is_file_op(input exu_op_type op);
		is_file_op = (op == decrement_register_op) || (op == decrement_skip_zero_op) ||
			(op == increment_skip_zero_op);
	endfunction

	// ==========================================================
	// state
	exu_state_type state_ff;
	exu_state_type nxt_state;
	logic [DATA_W-1:0] file_ff [FILE_DEPTH];
	logic [DATA_W-1:0] work_ff;
	logic [DATA_W-1:0] nxt_work;
	logic zero_ff;
	logic nxt_zero;
	logic [`EXU_PC_W-1:0] pc_ff;
	logic [`EXU_PC_W-1:0] nxt_pc;
	logic [`EXU_LATCH_W-1:0] latch_ff;
	logic [`EXU_LATCH_W-1:0] nxt_latch;
	logic [DATA_W-1:0] rdata_ff;
	logic [DATA_W-1:0] nxt_rdata;

	// ==========================================================
	// instruction decode and datapath
	logic exec;
	logic op_dec;
	logic op_clear;
	logic op_dec_skip;
	logic op_inc_skip;
	logic op_branch;
	logic op_or;
	logic [DATA_W-1:0] file_rd;
	logic [DATA_W-1:0] dec_res;
	logic [DATA_W-1:0] inc_res;
	logic [DATA_W-1:0] alu_res;
	logic writes_file;
	logic writes_work;
	logic upd_zero;
	logic skip_taken;
	logic [`EXU_PC_W-1:0] branch_pc;

	// an instruction is only taken outside the forced no-operation slot
	assign INSTR_READY = (state_ff == EXU_RUN);
	assign exec = INSTR_VALID && INSTR_READY;
	assign op_dec = (INSTR_OP == decrement_register_op);
	assign op_clear = (INSTR_OP == clear_working_op);
	assign op_dec_skip = (INSTR_OP == decrement_skip_zero_op);
	assign op_inc_skip = (INSTR_OP == increment_skip_zero_op);
	assign op_branch = (INSTR_OP == unconditional_branch_op);
	assign op_or = (INSTR_OP == or_literal_op);

	// file index beyond the implemented depth reads as zero
	assign file_rd = (int'(INSTR_FILE) < FILE_DEPTH) ? file_ff[INSTR_FILE] : '0;
	assign dec_res = DATA_W'(file_rd - 1'b1);
	assign inc_res = DATA_W'(file_rd + 1'b1);

	// result select; clear yields zero, or merges the low literal byte into the working reg
	assign alu_res = (op_dec || op_dec_skip) ? dec_res :
		op_inc_skip ? inc_res :
		op_or ? (work_ff | INSTR_LIT[DATA_W-1:0]) :
		`EXU_RST_DATA;

	// destination bit steers file ops; clear and or always land in working reg
	assign writes_file = exec && is_file_op(INSTR_OP) && INSTR_DEST;
	assign writes_work = exec && ((is_file_op(INSTR_OP) && !INSTR_DEST) || op_clear || op_or);
	// skips and branch keep status as it was
	assign upd_zero = exec && (op_dec || op_clear || op_or);
	assign skip_taken = exec && (op_dec_skip || op_inc_skip) && is_zero(alu_res);

	// branch target: page bits from the latch, low bits from the operand
	assign branch_pc = {latch_ff[`EXU_LATCH_PAGE_MSB:`EXU_LATCH_PAGE_LSB],
		INSTR_LIT[`EXU_PC_LOW_MSB:0]};

	// ==========================================================
	// next-state selection
	// a taken skip steps over the next word and burns one no-operation cycle
	assign nxt_state = (exec && (op_branch || skip_taken)) ?
		EXU_NOP_SLOT : EXU_RUN;
	assign nxt_pc = (exec && op_branch) ? branch_pc :
		skip_taken ? `EXU_PC_W'(pc_ff + `EXU_PC_SKIP_STEP) :
		exec ? `EXU_PC_W'(pc_ff + `EXU_PC_STEP) :
		pc_ff;
	// instruction write wins over a register-port write in the same cycle
	assign nxt_work = writes_work ? alu_res :
		(REG_WR && REG_ADDR == `EXU_OFS_WORK) ? REG_WDATA :
		work_ff;
	// clear forces the flag, the others report their result
	assign nxt_zero = upd_zero ? (op_clear ? 1'b1 : is_zero(alu_res)) : zero_ff;
	assign nxt_latch = (REG_WR && REG_ADDR == `EXU_OFS_LATCH) ?
		REG_WDATA[`EXU_LATCH_W-1:0] : latch_ff;

	// register port read mux; unmapped offsets read zero
	assign nxt_rdata = !REG_RD ? '0 :
		(REG_ADDR <= `EXU_OFS_FILE_LAST) ?
			((int'(REG_ADDR) < FILE_DEPTH) ? file_ff[REG_ADDR[`EXU_FILE_AW-1:0]] : '0) :
		(REG_ADDR == `EXU_OFS_WORK) ? work_ff :
		(REG_ADDR == `EXU_OFS_STATUS) ? DATA_W'(zero_ff) :
		(REG_ADDR == `EXU_OFS_LATCH) ? DATA_W'(latch_ff) :
		(REG_ADDR == `EXU_OFS_PC_LOW) ? pc_ff[DATA_W-1:0] :
		(REG_ADDR == `EXU_OFS_PC_HIGH) ? DATA_W'(pc_ff[`EXU_PC_W-1:DATA_W]) :
		'0;

	// ==========================================================
	// data file, one register per index
	for (genvar i = 0; i < FILE_DEPTH; i++) begin : g_file
		logic [DATA_W-1:0] nxt_file;
		assign nxt_file = (writes_file && int'(INSTR_FILE) == i) ? alu_res :
			(REG_WR && int'(REG_ADDR) == i) ? REG_WDATA :
			file_ff[i];
		always_ff @(posedge SYS_CLK or negedge NRST) begin
			if (!NRST) begin
				file_ff[i] <= `EXU_RST_DATA;
			end else begin
				file_ff[i] <= nxt_file;
			end
		end
	end

	// core registers
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			state_ff <= EXU_RUN;
			work_ff <= `EXU_RST_DATA;
			zero_ff <= 1'b0;
			pc_ff <= `EXU_RST_PC;
			latch_ff <= `EXU_RST_LATCH;
		end else begin
			state_ff <= nxt_state;
			work_ff <= nxt_work;
			zero_ff <= nxt_zero;
			pc_ff <= nxt_pc;
			latch_ff <= nxt_latch;
		end
	end

	// read data stands only in the cycle after the read strobe
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			rdata_ff <= `EXU_RST_DATA;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// outputs
	assign PC_OUT = pc_ff;
	assign WORK_OUT = work_ff;
	assign ZERO_OUT = zero_ff;
	assign NOP_CYCLE = (state_ff == EXU_NOP_SLOT);
	assign REG_RDATA = rdata_ff;

	// ==========================================================
	// assertions
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);

	// forced no-operation slot followed by a return to accepting
	sequence seq_nop_slot;
		NOP_CYCLE && !INSTR_READY ##1 INSTR_READY;
	endsequence

	sequence seq_dec_skip_zero;
		exec && op_dec_skip && file_rd == DATA_W'(1);
	endsequence

	sequence seq_inc_skip_zero;
		exec && op_inc_skip && file_rd == {DATA_W{1'b1}};
	endsequence

	// a file-destination instruction inside the implemented depth; beyond it the write
	// is dropped on purpose, so the file checks only look at real registers
	sequence seq_file_dest;
		exec && INSTR_DEST && int'(INSTR_FILE) < FILE_DEPTH;
	endsequence

	// straight-line completion: still accepting, no slot, pc one word on
	sequence seq_run_on;
		INSTR_READY && !NOP_CYCLE && PC_OUT == `EXU_PC_W'($past(pc_ff) + `EXU_PC_STEP);
	endsequence

	a_dec_to_work: assert property (
		exec && op_dec && !INSTR_DEST |=> WORK_OUT == DATA_W'($past(file_rd) - 1'b1)
	) else $error("decrement to working register gave wrong value");

	a_clear_work: assert property (
		exec && op_clear |=> WORK_OUT == '0 && ZERO_OUT && $stable(latch_ff)
	) else $error("clear working register did not clear and set zero");

	a_dec_skip_flags: assert property (
		exec && op_dec_skip |=> ZERO_OUT == $past(zero_ff)
	) else $error("decrement-and-skip changed the zero flag");

	a_dec_skip_nop: assert property (
		seq_dec_skip_zero |=> seq_nop_slot
	) else $error("decrement-and-skip to zero did not insert one no-operation cycle");

	a_inc_skip_flags: assert property (
		exec && op_inc_skip && !INSTR_DEST |=> WORK_OUT == DATA_W'($past(file_rd) + 1'b1)
			&& ZERO_OUT == $past(zero_ff)
	) else $error("increment-and-skip result or flag wrong");

	a_inc_skip_nop: assert property (
		seq_inc_skip_zero |=> seq_nop_slot ##0
			PC_OUT == `EXU_PC_W'($past(pc_ff, 2) + `EXU_PC_SKIP_STEP)
	) else $error("increment-and-skip to zero did not skip the next word");

	a_branch_low: assert property (
		exec && op_branch |=> PC_OUT[`EXU_PC_LOW_MSB:0] == $past(INSTR_LIT)
	) else $error("branch low pc bits not loaded from operand");

	a_branch_page: assert property (
		exec && op_branch |=> PC_OUT[`EXU_PC_W-1:`EXU_PC_HIGH_LSB] ==
			$past(latch_ff[`EXU_LATCH_PAGE_MSB:`EXU_LATCH_PAGE_LSB])
	) else $error("branch page bits not taken from latch");

	a_branch_two: assert property (
		exec && op_branch |=> seq_nop_slot ##0 ZERO_OUT == $past(zero_ff, 2)
	) else $error("branch did not take two cycles or changed the flag");

	a_or_literal: assert property (
		exec && op_or |=> WORK_OUT == ($past(work_ff) | $past(INSTR_LIT[DATA_W-1:0]))
	) else $error("or-literal gave wrong working register");

	a_zero_update: assert property (
		upd_zero |=> ZERO_OUT == ($past(alu_res) == '0 || $past(op_clear))
	) else $error("zero flag does not match the result");

	a_single_cycle: assert property (
		exec && !op_branch && !skip_taken |=> INSTR_READY && !NOP_CYCLE
	) else $error("single-cycle instruction stalled the unit");

	// ==========================================================
	// file destination: the result lands back in the indexed register
	a_dec_to_file: assert property (
		seq_file_dest ##0 op_dec |=>
			file_ff[$past(INSTR_FILE)] == DATA_W'($past(file_rd) - 1'b1)
	) else $error("decrement to file register gave wrong value");

	a_dec_skip_route: assert property (
		seq_file_dest ##0 op_dec_skip |=>
			file_ff[$past(INSTR_FILE)] == DATA_W'($past(file_rd) - 1'b1)
	) else $error("decrement-and-skip did not write back to the file register");

	a_inc_skip_route: assert property (
		seq_file_dest ##0 op_inc_skip |=>
			file_ff[$past(INSTR_FILE)] == DATA_W'($past(file_rd) + 1'b1)
	) else $error("increment-and-skip did not write back to the file register");

	// a file-destination op must leave the working register alone
	a_file_keeps_work: assert property (
		exec && is_file_op(INSTR_OP) && INSTR_DEST && !REG_WR |=> $stable(WORK_OUT)
	) else $error("file-destination instruction changed the working register");

	// ==========================================================
	// skips that miss zero, and the forced slot itself
	a_dec_skip_run_on: assert property (
		exec && op_dec_skip && file_rd != DATA_W'(1) |=> seq_run_on
	) else $error("decrement-and-skip to a non-zero result did not run on");

	a_inc_skip_run_on: assert property (
		exec && op_inc_skip && file_rd != {DATA_W{1'b1}} |=> seq_run_on
	) else $error("increment-and-skip to a non-zero result did not run on");

	// nothing is taken in the slot, so pc and flag must hold through it
	a_nop_slot_hold: assert property (
		NOP_CYCLE |=> $stable(PC_OUT) && $stable(ZERO_OUT)
	) else $error("pc or zero flag moved during the no-operation slot");

	// plain one-cycle ops step the pc by a single word
	a_pc_step: assert property (
		exec && (op_dec || op_clear || op_or) |=> seq_run_on
	) else $error("one-cycle instruction did not step the pc by one");

	// ==========================================================
	// register port: data stand one cycle after the strobe, zero otherwise
	a_read_idle: assert property (
		!REG_RD |=> REG_RDATA == '0
	) else $error("read data not zero outside the read cycle");

	a_read_work: assert property (
		REG_RD && REG_ADDR == `EXU_OFS_WORK |=> REG_RDATA == $past(work_ff)
	) else $error("working register read gave wrong data");

endmodule

// *** test/exu_execute_tb.sv ***
// self-checking bench for the instruction execute subset
`timescale 1ns/1ps
`include "exu_consts.svh"

module exu_execute_tb;
	import exu_pkg::*;
	// ==========
	// design ports and reference state
	logic sys_clk, nrst, instr_valid, instr_dest, instr_ready, zero_out, nop_cycle;
	logic reg_wr, reg_rd;
	exu_op_type instr_op;
	logic [`EXU_FILE_AW-1:0] instr_file;
	logic [`EXU_LIT_W-1:0] instr_lit;
	logic [`EXU_PC_W-1:0] pc_out, m_pc;
	logic [7:0] work_out, reg_addr, reg_wdata, reg_rdata, m_work;
	logic [7:0] m_file [128];
	logic [6:0] m_latch;
	logic m_zero, m_two;
	int n_errors, n_compared;

	exu_execute dut (.SYS_CLK(sys_clk), .NRST(nrst), .INSTR_VALID(instr_valid),
		.INSTR_OP(instr_op), .INSTR_FILE(instr_file), .INSTR_DEST(instr_dest),
		.INSTR_LIT(instr_lit), .INSTR_READY(instr_ready), .PC_OUT(pc_out),
		.WORK_OUT(work_out), .ZERO_OUT(zero_out), .NOP_CYCLE(nop_cycle),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata));

	// 100 MHz core clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ==========
	// checking helpers
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// core state is compared mid-cycle, once the take edge has landed
	task automatic state_chk;
		@(negedge sys_clk);
		chk("work", 16'(m_work), 16'(work_out));
		chk("zero", 16'(m_zero), 16'(zero_out));
		chk("pc", 16'(m_pc), 16'(pc_out));
		chk("nop slot", 16'(m_two), 16'(nop_cycle));
		chk("ready", 16'(!m_two), 16'(instr_ready));
	endtask

	// ==========
	// reference model
	function automatic logic [7:0] result(exu_op_type op, logic [7:0] fv, logic [7:0] k);
		case (op)
			decrement_register_op, decrement_skip_zero_op: return fv - 8'h01;
			increment_skip_zero_op: return fv + 8'h01;
			or_literal_op: return m_work | k;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] exp_read(logic [7:0] a);
		if (a <= 8'h7f) return m_file[a[6:0]];
		if (a == 8'h80) return m_work;
		if (a == 8'h81) return {7'h00, m_zero};
		if (a == 8'h82) return {1'b0, m_latch};
		if (a == 8'h83) return m_pc[7:0];
		if (a == 8'h84) return {1'b0, m_pc[14:8]};
		return 8'h00;
	endfunction

	task automatic model(exu_op_type op, logic [6:0] f, logic d, logic [10:0] k);
		logic [7:0] r;
		r = result(op, m_file[f], k[7:0]);
		m_pc = m_pc + 15'h0001;
		if (op inside {decrement_register_op, decrement_skip_zero_op, increment_skip_zero_op}) begin
			if (d) m_file[f] = r;
			else m_work = r;
			if (op == decrement_register_op) m_zero = (r == 8'h00);
			else if (r == 8'h00) begin
				m_two = 1'b1;
				m_pc = m_pc + 15'h0001;
			end
		end else if (op == clear_working_op || op == or_literal_op) begin
			m_work = r;
			m_zero = (r == 8'h00);
		end else if (op == unconditional_branch_op) begin
			m_pc = {m_latch[6:3], k};
			m_two = 1'b1;
		end
	endtask

	// ==========
	// drivers: each is entered and left at a rising edge
	task automatic exec(exu_op_type op, logic [6:0] f, logic d, logic [10:0] k);
		bit taken;
		taken = 1'b0;
		instr_valid <= 1'b1;
		instr_op <= op;
		instr_file <= f;
		instr_dest <= d;
		instr_lit <= k;
		state_chk();
		m_two = 1'b0;
		// a held request during the no-operation slot must be refused, so allow a retry
		for (int i = 0; i < 4 && !taken; i++) begin
			if (i > 0) @(negedge sys_clk);
			taken = (instr_ready === 1'b1);
			@(posedge sys_clk);
		end
		if (!taken) begin
			n_errors++;
			$display("CHECK FAILED handshake expected taken seen stuck");
			tally_and_finish();
		end else begin
			model(op, f, d, k);
		end
	endtask

	task automatic settle;
		instr_valid <= 1'b0;
		state_chk();
		m_two = 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic reg_write(logic [7:0] a, logic [7:0] v);
		settle();
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		if (a <= 8'h7f) m_file[a[6:0]] = v;
		else if (a == 8'h80) m_work = v;
		else if (a == 8'h82) m_latch = v[6:0];
	endtask

	task automatic reg_read(logic [7:0] a);
		settle();
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk("read data", 16'(exp_read(a)), 16'(reg_rdata));
		@(negedge sys_clk);
		chk("read idle", 16'h0000, 16'(reg_rdata));
		@(posedge sys_clk);
	endtask

	// ==========
	// main sequence
	initial begin
		nrst = 1'b0;
		{instr_valid, instr_dest, reg_wr, reg_rd} = 4'h0;
		instr_op = nop_op;
		instr_file = 7'h00;
		instr_lit = 11'h000;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		{m_work, m_latch, m_zero, m_two} = 17'h0_0000;
		m_pc = 15'h0000;
		n_errors = 0;
		n_compared = 0;
		foreach (m_file[i]) m_file[i] = 8'h00;
		void'($urandom(91));
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		for (int a = 8'h7e; a <= 8'h90; a++) reg_read(8'(a));
		$display("test reset and map done");
		// corner cases: skips on exact zero, wrap, flags held, branch page bits
		reg_write(8'h05, 8'h01);
		exec(decrement_skip_zero_op, 7'h05, 1'b0, 11'h000);
		exec(decrement_register_op, 7'h05, 1'b1, 11'h000);
		exec(increment_skip_zero_op, 7'h05, 1'b1, 11'h000);
		exec(clear_working_op, 7'h05, 1'b0, 11'h000);
		reg_write(8'h82, 8'h48);
		exec(unconditional_branch_op, 7'h00, 1'b0, 11'h123);
		exec(or_literal_op, 7'h00, 1'b0, 11'h700);
		exec(decrement_register_op, 7'h06, 1'b0, 11'h000);
		exec(increment_skip_zero_op, 7'h06, 1'b0, 11'h000);
		exec(decrement_skip_zero_op, 7'h06, 1'b1, 11'h000);
		exec(increment_skip_zero_op, 7'h06, 1'b0, 11'h000);
		reg_write(8'h82, 8'h7f);
		exec(unconditional_branch_op, 7'h00, 1'b0, 11'h7ff);
		exec(nop_op, 7'h00, 1'b0, 11'h000);
		reg_write(8'h81, 8'hff);
		reg_write(8'h83, 8'hff);
		for (int a = 8'h80; a <= 8'h84; a++) reg_read(8'(a));
		$display("test corner cases done");
		// random traffic over a few file registers, with port writes among it
		repeat (300) begin
			if ($urandom_range(7, 0) == 0)
				reg_write(8'h80 + 8'($urandom_range(4, 0)), 8'($urandom));
			else
				exec(exu_op_type'($urandom_range(6, 0)), 7'($urandom_range(7, 0)),
					1'($urandom), 11'($urandom));
		end
		for (int a = 0; a < 8; a++) reg_read(8'(a));
		$display("test random traffic done");
		tally_and_finish();
	end
endmodule
